// ### front_panel_menu_fsm.v
// Front-panel menu controller: lockout, display states, scrolling, edits.
// How it works
// - Lockout is on after reset.
// - Locked panel ignores switches, lamp lit.
// - Clock, position, frame held together unlock.
// - Set on time code shows names.
// - Set on name shows its value.
// - Set on value stores, returns to time code.
// - Up/down step through parameter names.
// - Up/down step through permitted values.
// - Held up/down auto-repeats the step.
// - Up plus down cycles time-code fields.
// - Run/stop on time code toggles generator in preset mode.
// - Run/stop on time code clears counter outside preset mode.
// - Run/stop elsewhere cancels without storing.
// - Name state reopens last used parameter.
// - Output level steps by three decibels.
// - Host-only functions absent from menu.
`default_nettype none
`include "panel_menu_defines.vh"
module front_panel_menu_fsm #(
    parameter integer DEBOUNCE_CYC = `DEBOUNCE_CYCLES,
    parameter integer REPEAT_DELAY = `REPEAT_DELAY_CYC,
    parameter integer REPEAT_RATE  = `REPEAT_RATE_CYC
) (
    input  wire                  i_clock,
    input  wire                  i_rst_n,
    input  wire                  i_sw_set,
    input  wire                  i_sw_down,
    input  wire                  i_sw_up,
    input  wire                  i_sw_run,
    input  wire                  i_sw_clock_ref,
    input  wire                  i_sw_pos_ref,
    input  wire                  i_sw_frame_rate,
    input  wire                  i_host_lockout_set,
    input  wire                  i_host_lockout_clear,
    input  wire                  i_generator_preset_mode,
    input  wire [`VALUE_W-1:0]   i_param_value,
    output reg  [1:0]            o_display_state,
    output reg  [`PARAM_W-1:0]   o_param_select,
    output reg  [`VALUE_W-1:0]   o_edit_value,
    output reg  [1:0]            o_edit_field,
    output reg                   o_value_store,
    output reg                   o_generator_run,
    output reg                   o_counter_reset,
    output reg                   o_remote_only_lamp,
    output reg                   o_clock_ref_step,
    output reg                   o_pos_ref_step,
    output reg                   o_frame_rate_step
);

wire [`SW_COUNT-1:0] raw_sw;
wire [`SW_COUNT-1:0] level_sw;
reg  [`SW_COUNT-1:0] last_q;
wire [`SW_COUNT-1:0] press;

assign raw_sw = {i_sw_frame_rate, i_sw_pos_ref, i_sw_clock_ref,
                 i_sw_run, i_sw_up, i_sw_down, i_sw_set};

genvar g;
generate
    for (g = 0; g < `SW_COUNT; g = g + 1) begin : gen_sw
        switch_conditioner #(
            .COUNT (DEBOUNCE_CYC)
        ) u_cond (
            .i_clock (i_clock),
            .i_rst_n (i_rst_n),
            .i_raw   (raw_sw[g]),
            .o_level (level_sw[g])
        );
    end
endgenerate

// Edges are tracked while locked as well, so a switch still held when the
// lock drops does not fire an event.
// one pulse per press.
assign press = level_sw & ~last_q;

wire up_held;
wire down_held;
wire both_held;
wire unlock_combo;
assign up_held      = level_sw[`SW_UP];
assign down_held    = level_sw[`SW_DOWN];
assign both_held    = up_held & down_held;
assign unlock_combo = level_sw[`SW_CLKREF] & level_sw[`SW_POSREF]
                      & level_sw[`SW_FRAME];

reg                  lock_q;
reg                  combo_seen_q;
reg [`REPEAT_W-1:0]  rpt_cnt_q;
reg                  rpt_fast_q;
reg                  both_q;
wire                 rpt_tick;
wire                 step_up;
wire                 step_down;
wire                 both_press;

assign rpt_tick = (up_held ^ down_held) &&
                  (rpt_fast_q ? rpt_cnt_q == REPEAT_RATE[`REPEAT_W-1:0]
                              : rpt_cnt_q == REPEAT_DELAY[`REPEAT_W-1:0]);

// A chord is both switches down; it suppresses single steps so that a
// slightly staggered release does not also move the value.
assign both_press = both_held & ~both_q;
assign step_up    = up_held & ~down_held & (press[`SW_UP] | rpt_tick);
assign step_down  = down_held & ~up_held & (press[`SW_DOWN] | rpt_tick);

always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
        rpt_cnt_q  <= {`REPEAT_W{1'b0}};
        rpt_fast_q <= 1'b0;
    end else if (!(up_held ^ down_held)) begin
        rpt_cnt_q  <= {`REPEAT_W{1'b0}};
        rpt_fast_q <= 1'b0;
    end else if (rpt_tick) begin
        rpt_cnt_q  <= {`REPEAT_W{1'b0}};
        rpt_fast_q <= 1'b1;
    end else begin
        rpt_cnt_q <= rpt_cnt_q + 1'b1;
    end
end

reg [1:0]           state_q;
reg [1:0]           state_d;
reg [`PARAM_W-1:0]  sel_q;
reg [`PARAM_W-1:0]  sel_d;
reg [`VALUE_W-1:0]  val_q;
reg [`VALUE_W-1:0]  val_d;
reg [1:0]           field_q;
reg [1:0]           field_d;
reg                 gen_q;
reg                 gen_d;
reg                 store_d;
reg                 clr_d;
wire                active;

assign active = ~lock_q;

function [`VALUE_W-1:0] val_max;
    input [`PARAM_W-1:0] p;
    begin
        val_max = (p == `PARAM_LTC_LEVEL) ? `LEVEL_MAX : `VALUE_MAX_DEFAULT;
    end
endfunction

function [`VALUE_W-1:0] val_min;
    input [`PARAM_W-1:0] p;
    begin
        val_min = (p == `PARAM_LTC_LEVEL) ? `LEVEL_MIN : 8'h00;
    end
endfunction

function [`VALUE_W-1:0] val_stp;
    input [`PARAM_W-1:0] p;
    begin
        // level moves three dB a step.
        val_stp = (p == `PARAM_LTC_LEVEL) ? `LEVEL_STEP : 8'h01;
    end
endfunction

wire [`PARAM_W-1:0] sel_last;
wire [`PARAM_W-1:0] sel_next_up;
wire [`PARAM_W-1:0] sel_next_dn;
wire [`VALUE_W-1:0] range_hi;
wire [`VALUE_W-1:0] range_lo;
wire [`VALUE_W-1:0] range_step;
wire                val_can_inc;
wire                val_can_dec;
wire [`VALUE_W-1:0] val_inc;
wire [`VALUE_W-1:0] val_dec;
wire [1:0]          field_next;

// The name list wraps at both ends, so the index never leaves the list.
assign sel_last    = `PARAM_COUNT - 5'h01;
assign sel_next_up = (sel_q == sel_last) ? `PARAM_GENERATOR
                                         : sel_q + 5'h01;
assign sel_next_dn = (sel_q == `PARAM_GENERATOR) ? sel_last
                                                 : sel_q - 5'h01;

// Values compare as signed so the negative level range keeps its order;
// a value loaded off the step grid stops short of a limit, never past it.
assign range_hi    = val_max(sel_q);
assign range_lo    = val_min(sel_q);
assign range_step  = val_stp(sel_q);
assign val_can_inc = $signed(val_q) <= $signed(range_hi - range_step);
assign val_can_dec = $signed(val_q) >= $signed(range_lo + range_step);
assign val_inc     = val_q + range_step;
assign val_dec     = val_q - range_step;
assign field_next  = (field_q == `FIELD_FRAMES) ? `FIELD_HOURS
                                                : field_q + 2'h1;

always @* begin
    state_d = state_q;
    sel_d   = sel_q;
    val_d   = val_q;
    field_d = field_q;
    gen_d   = gen_q;
    store_d = 1'b0;
    clr_d   = 1'b0;
    if (active) begin
        case (state_q)
            `ST_TIMECODE: begin
                if (press[`SW_SET]) begin
                    // selection is kept from last use.
                    state_d = `ST_NAME;
                end else if (press[`SW_RUN]) begin
                    if (i_generator_preset_mode) begin
                        gen_d = ~gen_q;
                    end else begin
                        clr_d = 1'b1;
                    end
                end
            end
            `ST_NAME: begin
                if (press[`SW_SET]) begin
                    state_d = `ST_VALUE;
                    val_d   = i_param_value;
                    field_d = `FIELD_HOURS;
                end else if (press[`SW_RUN]) begin
                    state_d = `ST_TIMECODE;
                end else if (step_up) begin
                    sel_d = sel_next_up;
                end else if (step_down) begin
                    sel_d = sel_next_dn;
                end
            end
            `ST_VALUE: begin
                if (press[`SW_SET]) begin
                    store_d = 1'b1;
                    state_d = `ST_TIMECODE;
                end else if (press[`SW_RUN]) begin
                    state_d = `ST_TIMECODE;
                end else if (both_press && sel_q == `PARAM_GENERATOR) begin
                    field_d = field_next;
                end else if (step_up) begin
                    if (val_can_inc) begin
                        val_d = val_inc;
                    end
                end else if (step_down) begin
                    if (val_can_dec) begin
                        val_d = val_dec;
                    end
                end
            end
            default: begin
                state_d = `ST_TIMECODE;
            end
        endcase
    end
end

// Host set beats host clear, which beats the chord; the chord acts on its
// first cycle only, so holding it through a host set does not reopen.
reg lock_d;
always @* begin
    lock_d = lock_q;
    if (i_host_lockout_set) begin
        lock_d = 1'b1;
    end else if (i_host_lockout_clear) begin
        lock_d = 1'b0;
    end else if (lock_q && unlock_combo && !combo_seen_q) begin
        lock_d = 1'b0;
    end
end

always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
        lock_q       <= 1'b1;
        combo_seen_q <= 1'b0;
        last_q       <= {`SW_COUNT{1'b0}};
        both_q       <= 1'b0;
        state_q      <= `ST_TIMECODE;
        sel_q        <= `PARAM_GENERATOR;
        val_q        <= {`VALUE_W{1'b0}};
        field_q      <= `FIELD_HOURS;
        gen_q        <= 1'b0;
    end else begin
        last_q  <= level_sw;
        both_q  <= both_held;
        state_q <= state_d;
        sel_q   <= sel_d;
        val_q   <= val_d;
        field_q <= field_d;
        gen_q   <= gen_d;
        combo_seen_q <= unlock_combo;
        lock_q       <= lock_d;
    end
end

wire [2:0] ref_step_d;

// Reference switches step their settings only when the panel is live and
// not forming the unlock chord, so releasing the chord changes nothing.
// one step per reference press.
genvar r;
generate
    for (r = 0; r < 3; r = r + 1) begin : gen_ref
        assign ref_step_d[r] = active & press[`SW_CLKREF + r]
                               & ~unlock_combo;
    end
endgenerate

always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_display_state    <= `ST_TIMECODE;
        o_param_select     <= `PARAM_GENERATOR;
        o_edit_value       <= {`VALUE_W{1'b0}};
        o_edit_field       <= `FIELD_HOURS;
        o_value_store      <= 1'b0;
        o_generator_run    <= 1'b0;
        o_counter_reset    <= 1'b0;
        o_remote_only_lamp <= 1'b1;
        o_clock_ref_step   <= 1'b0;
        o_pos_ref_step     <= 1'b0;
        o_frame_rate_step  <= 1'b0;
    end else begin
        o_display_state    <= state_d;
        o_param_select     <= sel_d;
        o_edit_value       <= val_d;
        o_edit_field       <= field_d;
        o_value_store      <= store_d;
        o_generator_run    <= gen_d;
        o_counter_reset    <= clr_d;
        o_remote_only_lamp <= lock_q;
        o_clock_ref_step   <= ref_step_d[0];
        o_pos_ref_step     <= ref_step_d[1];
        o_frame_rate_step  <= ref_step_d[2];
    end
end

endmodule
`default_nettype wire

// ### front_panel_menu_properties.sv
// Port-level assertion checker for the front-panel menu controller.
`include "panel_menu_defines.vh"
`default_nettype none
module front_panel_menu_properties (
    input wire logic                i_clock,
    input wire logic                i_rst_n,
    input wire logic                i_generator_preset_mode,
    input wire logic [`VALUE_W-1:0] i_param_value,
    input wire logic [1:0]          o_display_state,
    input wire logic [`PARAM_W-1:0] o_param_select,
    input wire logic [`VALUE_W-1:0] o_edit_value,
    input wire logic [1:0]          o_edit_field,
    input wire logic                o_value_store,
    input wire logic                o_generator_run,
    input wire logic                o_counter_reset,
    input wire logic                o_remote_only_lamp
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    reset_locked_a: assert property (
        $rose(i_rst_n) |-> o_remote_only_lamp) else $error("not locked");
    lock_freeze_a: assert property (
        o_remote_only_lamp && $past(o_remote_only_lamp) |-> !o_value_store
        && !o_counter_reset && $stable(o_display_state)) else $error("lock");
    value_load_a: assert property (
        $past(o_display_state) == `ST_NAME && o_display_state == `ST_VALUE
        |-> o_edit_value == $past(i_param_value)) else $error("load");
    store_return_a: assert property (
        o_value_store |-> o_display_state == `ST_TIMECODE
        && $past(o_display_state) == `ST_VALUE) else $error("store");
    select_name_a: assert property (
        o_param_select != $past(o_param_select)
        |-> $past(o_display_state) == `ST_NAME) else $error("select");
    field_step_a: assert property (
        o_display_state == `ST_VALUE && $past(o_display_state) == `ST_VALUE
        && o_edit_field != $past(o_edit_field)
        |-> o_edit_field == $past(o_edit_field) + 2'h1) else $error("field");
    gen_toggle_a: assert property (
        o_generator_run != $past(o_generator_run) |-> $past(
        i_generator_preset_mode) && $past(o_display_state) == `ST_TIMECODE)
        else $error("generator");
    counter_clear_a: assert property (
        o_counter_reset |-> !$past(i_generator_preset_mode)
        && $past(o_display_state) == `ST_TIMECODE) else $error("clear");
    level_step_a: assert property (
        o_display_state == `ST_VALUE && $past(o_display_state) == `ST_VALUE
        && o_param_select == `PARAM_LTC_LEVEL
        && o_edit_value != $past(o_edit_value)
        |-> o_edit_value - $past(o_edit_value) inside {8'h03, 8'hFD})
        else $error("level step");
endmodule
bind front_panel_menu_fsm front_panel_menu_properties chk_i (
    .i_clock, .i_rst_n, .i_generator_preset_mode, .i_param_value,
    .o_display_state, .o_param_select, .o_edit_value, .o_edit_field,
    .o_value_store, .o_generator_run, .o_counter_reset, .o_remote_only_lamp);
`default_nettype wire

// ### panel_menu_defines.vh
// Constants shared by the front-panel menu controller and its debouncer.
`ifndef PANEL_MENU_DEFINES_VH
`define PANEL_MENU_DEFINES_VH

`define CLK_PERIOD_NS      8
`define DEBOUNCE_TIME_US   10
`define DEBOUNCE_CYCLES    ((`DEBOUNCE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define DEBOUNCE_W         11
`define REPEAT_DELAY_MS    400
`define REPEAT_DELAY_CYC   ((`REPEAT_DELAY_MS * 1000000) / `CLK_PERIOD_NS)
`define REPEAT_RATE_MS     80
`define REPEAT_RATE_CYC    ((`REPEAT_RATE_MS * 1000000) / `CLK_PERIOD_NS)
`define REPEAT_W           26

`define SW_COUNT           7
`define SW_SET             0
`define SW_DOWN            1
`define SW_UP              2
`define SW_RUN             3
`define SW_CLKREF          4
`define SW_POSREF          5
`define SW_FRAME           6

`define ST_TIMECODE        2'h0
`define ST_NAME            2'h1
`define ST_VALUE           2'h2

`define PARAM_W            5
`define PARAM_COUNT        5'h11
`define PARAM_GENERATOR    5'h00
`define PARAM_LTC_LEVEL    5'h01

`define VALUE_W            8
`define LEVEL_MIN          8'hE8
`define LEVEL_MAX          8'h09
`define LEVEL_STEP         8'h03
`define LEVEL_RESET        8'hFA
`define VALUE_MAX_DEFAULT  8'h0F

`define FIELD_HOURS        2'h0
`define FIELD_FRAMES       2'h3

`endif

// ### panel_operator.sv
// Behavioural operator pressing and releasing the panel switches.
`default_nettype none
module panel_operator (
    input  wire logic       i_clock,
    output var  logic [6:0] o_sw
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_sw = 7'h00;
    // Held and released well past the debounce span, so one press is clean.
    task automatic hold(input logic [6:0] mask, input int n);
        @(negedge i_clock);
        o_sw = mask;
        repeat (n) @(negedge i_clock);
        o_sw = 7'h00;
        repeat (16) @(negedge i_clock);
    endtask
endmodule
`default_nettype wire

// ### switch_conditioner.v
// Two-stage synchroniser and stability-count debouncer for one switch.
`default_nettype none
module switch_conditioner #(
    parameter integer COUNT = 1250
) (
    input  wire i_clock,
    input  wire i_rst_n,
    input  wire i_raw,
    output reg  o_level
);
`include "panel_menu_defines.vh"

reg                   sync1_q;
reg                   sync2_q;
reg [`DEBOUNCE_W-1:0] cnt_q;

// The first stage feeds only the second, so no logic sees a metastable bit.
always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
        sync1_q <= 1'b0;
        sync2_q <= 1'b0;
        cnt_q   <= {`DEBOUNCE_W{1'b0}};
        o_level <= 1'b0;
    end else begin
        sync1_q <= i_raw;
        sync2_q <= sync1_q;
        if (sync2_q == o_level) begin
            cnt_q <= {`DEBOUNCE_W{1'b0}};
        end else if (cnt_q == COUNT[`DEBOUNCE_W-1:0] - 1'b1) begin
            cnt_q   <= {`DEBOUNCE_W{1'b0}};
            o_level <= sync2_q;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
end

endmodule
`default_nettype wire

// ### test_front_panel_menu_fsm.sv
// Self-checking bench for the front-panel menu controller.
`include "panel_menu_defines.vh"
`default_nettype none
module test_front_panel_menu_fsm;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [6:0] sw;
    logic       hset = 1'b0;
    logic       hclr = 1'b0;
    logic       mode = 1'b0;
    logic [7:0] pval = 8'hFA;
    logic [2:0] rstep;
    logic [1:0] st;
    logic [4:0] sel;
    logic [7:0] val;
    logic [1:0] fld;
    logic       store;
    logic       run;
    logic       crst;
    logic       lamp;
    int         n_mismatch = 0;
    int         checks = 0;
    int         n_store = 0;
    int         n_crst = 0;
    int         n_cref = 0;
    int         n_pref = 0;
    int         n_fref = 0;
    panel_operator op (.i_clock(clk), .o_sw(sw));
    front_panel_menu_fsm #(.DEBOUNCE_CYC(4), .REPEAT_DELAY(20),
        .REPEAT_RATE(8)) dut (
        .i_clock(clk), .i_rst_n(rst_n), .i_sw_set(sw[0]), .i_sw_down(sw[1]),
        .i_sw_up(sw[2]), .i_sw_run(sw[3]), .i_sw_clock_ref(sw[4]),
        .i_sw_pos_ref(sw[5]), .i_sw_frame_rate(sw[6]),
        .i_host_lockout_set(hset), .i_host_lockout_clear(hclr),
        .i_generator_preset_mode(mode), .i_param_value(pval),
        .o_display_state(st), .o_param_select(sel), .o_edit_value(val),
        .o_edit_field(fld), .o_value_store(store), .o_generator_run(run),
        .o_counter_reset(crst), .o_remote_only_lamp(lamp),
        .o_clock_ref_step(rstep[0]), .o_pos_ref_step(rstep[1]),
        .o_frame_rate_step(rstep[2]));
    initial begin
        forever #4 clk = ~clk;
    end
    always @(negedge clk) begin
        if (store === 1'b1) n_store++;
        if (crst === 1'b1) n_crst++;
        if (rstep[0] === 1'b1) n_cref++;
        if (rstep[1] === 1'b1) n_pref++;
        if (rstep[2] === 1'b1) n_fref++;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic t_locked();
        chk(lamp, 8'h01);
        op.hold(7'h01, 14);
        chk(st, `ST_TIMECODE);
        op.hold(7'h70, 14);
        chk(lamp, 8'h00);
        chk(n_cref + n_pref + n_fref, 8'h00);
    endtask
    task automatic t_ref();
        op.hold(7'h10, 14);
        chk(n_cref, 8'h01);
        op.hold(7'h20, 14);
        chk(n_pref, 8'h01);
        op.hold(7'h40, 14);
        chk(n_fref, 8'h01);
        op.hold(7'h70, 14);
        chk(n_cref + n_pref + n_fref, 8'h03);
        chk(lamp, 8'h00);
    endtask
    task automatic t_menu();
        op.hold(7'h01, 14);
        chk(st, `ST_NAME);
        op.hold(7'h04, 14);
        chk(sel, `PARAM_LTC_LEVEL);
        op.hold(7'h01, 14);
        chk(st, `ST_VALUE);
        chk(val, 8'hFA);
        op.hold(7'h04, 14);
        chk(val, 8'hFA + `LEVEL_STEP);
        op.hold(7'h02, 14);
        op.hold(7'h02, 14);
        chk(val, 8'hFA - `LEVEL_STEP);
        op.hold(7'h01, 14);
        chk(st, `ST_TIMECODE);
        chk(n_store, 8'h01);
    endtask
    task automatic t_field();
        op.hold(7'h01, 14);
        chk(sel, `PARAM_LTC_LEVEL);
        op.hold(7'h02, 14);
        chk(sel, `PARAM_GENERATOR);
        pval = 8'h05;
        op.hold(7'h01, 14);
        chk(val, 8'h05);
        op.hold(7'h06, 14);
        chk(fld, 8'h01);
        op.hold(7'h04, 14);
        chk(val, 8'h06);
        op.hold(7'h08, 14);
        chk(st, `ST_TIMECODE);
        chk(n_store, 8'h01);
    endtask
    task automatic t_run();
        op.hold(7'h08, 14);
        chk(n_crst, 8'h01);
        mode = 1'b1;
        op.hold(7'h08, 14);
        chk(run, 8'h01);
        op.hold(7'h08, 14);
        chk(run, 8'h00);
        chk(n_crst, 8'h01);
        mode = 1'b0;
    endtask
    task automatic t_repeat();
        op.hold(7'h01, 14);
        op.hold(7'h04, 48);
        // One step at the press, one after the hold delay, then one per
        // repeat period while the level stays up for 48 cycles.
        chk(sel, 8'h05);
        op.hold(7'h08, 14);
        chk(st, `ST_TIMECODE);
    endtask
    task automatic t_host();
        hset = 1'b1;
        @(negedge clk);
        hset = 1'b0;
        repeat (2) @(negedge clk);
        chk(lamp, 8'h01);
        op.hold(7'h01, 14);
        chk(st, `ST_TIMECODE);
        hclr = 1'b1;
        @(negedge clk);
        hclr = 1'b0;
        repeat (2) @(negedge clk);
        chk(lamp, 8'h00);
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_locked();
        t_menu();
        t_field();
        t_run();
        t_repeat();
        t_ref();
        t_host();
        print_verdict();
    end
    initial begin
        #50us;
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
